// *** hw/tla_pkg.sv ***
// tla_pkg: register map, config fields, reset values and carriers of the
// temperature limit alarm block.
// assumes its users, tla_alarm, tla_alarm_chk and tb, import it whole.
package tla_pkg;
  // register offsets on the serial port
  localparam logic [7:0] TLA_A_TEMP_MSB = 8'h00;
  localparam logic [7:0] TLA_A_TEMP_LSB = 8'h01;
  localparam logic [7:0] TLA_A_CONFIG = 8'h03;
  localparam logic [7:0] TLA_A_UPPER_MSB = 8'h04;
  localparam logic [7:0] TLA_A_UPPER_LSB = 8'h05;
  localparam logic [7:0] TLA_A_LOWER_MSB = 8'h06;
  localparam logic [7:0] TLA_A_LOWER_LSB = 8'h07;
  localparam logic [7:0] TLA_A_CRIT_MSB = 8'h08;
  localparam logic [7:0] TLA_A_CRIT_LSB = 8'h09;
  localparam logic [7:0] TLA_A_IDENT = 8'h0B;
  localparam logic [7:0] TLA_PTR_STEP = 8'h01;
  // configuration fields
  localparam int TLA_CFG_CRIT_POL = 2;
  localparam int TLA_CFG_ALM_POL = 3;
  localparam int TLA_CFG_CMP_MODE = 4;
  localparam int TLA_CFG_OPM_LO = 5;
  localparam logic [1:0] TLA_OPM_SHUTDOWN = 2'h3;
  // reset values: interrupt mode, continuous conversion, active low
  localparam logic [7:0] TLA_CFG_RST = 8'h00;
  localparam logic [15:0] TLA_UPPER_RST = 16'h3000;
  localparam logic [15:0] TLA_LOWER_RST = 16'h0400;
  localparam logic [15:0] TLA_CRIT_RST = 16'h4000;
  localparam logic [15:0] TLA_TEMP_RST = 16'h0000;
  // serial framing
  localparam logic [4:0] TLA_BUS_BASE = 5'h12;
  localparam logic [3:0] TLA_BIT_FIRST = 4'h1;
  localparam logic [3:0] TLA_LAST_BIT = 4'h7;
  localparam logic [3:0] TLA_ACK_BIT = 4'h8;
  localparam logic [3:0] TLA_BIT_STEP = 4'h1;

  typedef enum logic [2:0] {
    TLA_ST_ADDR = 3'b000,
    TLA_ST_PTR = 3'b001,
    TLA_ST_WDATA = 3'b010,
    TLA_ST_READ = 3'b011,
    TLA_ST_IDLE = 3'b100
  } tla_st_e;

  typedef enum logic [1:0] {
    TLA_EV_ADDR = 2'b00,
    TLA_EV_PTR = 2'b01,
    TLA_EV_DATA = 2'b10
  } tla_ev_e;

  // byte event handed from the serial clock to the system clock
  typedef struct packed {
    tla_ev_e kind;
    logic [7:0] data;
  } tla_evt_s;

  // open-drain pin: level to drive and low-active enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } tla_pin_s;
endpackage

// *** hw/tla_alarm.sv ***
// tla_alarm: limit alarm logic of a temperature sensor with its serial
// register port (serial-clocked side) and alarm compare (system clock).
// assumes temp_result/temp_valid and hyst_amount come from logic on clk;
// scl, sda_line and addr_sel are pins.
`timescale 1ns/1ps
module tla_alarm #(
  // identity value is arbitrary
  parameter logic [7:0] ID_CODE = 8'h5A
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda_line,
  output logic sda_drive,
  output logic sda_oe_n,
  input wire logic [1:0] addr_sel,
  input wire logic [15:0] temp_result,
  input wire logic temp_valid,
  input wire logic [15:0] hyst_amount,
  output logic [1:0] conv_mode,
  output tla_pkg::tla_pin_s limit_alarm_out,
  output tla_pkg::tla_pin_s critical_alarm_out
);
  import tla_pkg::*;

  // serial clock side
  logic start_tog_r, start_seen_r, ack_pend_r, evt_tog_r, drv_r, rd_tog_r, addr_hit;
  logic [1:0] sel_s1_r, sel_s2_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r, tx_r, byte_in;
  tla_st_e st_r;
  tla_evt_s evt_r;

  // system clock side
  logic [2:0] evt_sync_r, rd_sync_r;
  logic [7:0] cfg_r, ptr_r, rd_byte_r;
  logic [15:0] upper_r, lower_r, crit_r, temp_r, tsnap_r;
  logic evt_hit, rd_hit, wr_lock_r, alarm_r, src_hi_r, crit_alm_r, wr_en;
  logic shutdown, shut_entry, cmp_mode, new_res;
  logic above_hi, below_lo, under_hi_rel, over_lo_rel, above_crit, under_crit_rel;

  function automatic logic pair_msb(input logic [7:0] a);
    pair_msb = (a == TLA_A_TEMP_MSB) || (a == TLA_A_UPPER_MSB) ||
               (a == TLA_A_LOWER_MSB) || (a == TLA_A_CRIT_MSB);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input logic [15:0] t);
    case (a)
      TLA_A_TEMP_MSB: rd_mux = t[15:8];
      TLA_A_TEMP_LSB: rd_mux = t[7:0];
      TLA_A_CONFIG: rd_mux = cfg_r;
      TLA_A_UPPER_MSB: rd_mux = upper_r[15:8];
      TLA_A_UPPER_LSB: rd_mux = upper_r[7:0];
      TLA_A_LOWER_MSB: rd_mux = lower_r[15:8];
      TLA_A_LOWER_LSB: rd_mux = lower_r[7:0];
      TLA_A_CRIT_MSB: rd_mux = crit_r[15:8];
      TLA_A_CRIT_LSB: rd_mux = crit_r[7:0];
      TLA_A_IDENT: rd_mux = ID_CODE;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // a start is the data line falling while the clock is high; the toggle
  // is read only at the next clock rise, well after it has settled
  always_ff @(negedge sda_line or negedge rstn) begin
    if (!rstn) begin
      start_tog_r <= 1'b0;
    end else if (scl) begin
      start_tog_r <= ~start_tog_r;
    end
  end

  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      sel_s1_r <= 2'h0;
      sel_s2_r <= 2'h0;
    end else begin
      sel_s1_r <= addr_sel;
      sel_s2_r <= sel_s1_r;
    end
  end

  assign byte_in = {sh_r[6:0], sda_line};
  assign addr_hit = byte_in[7:1] == {TLA_BUS_BASE, sel_s2_r};

  // receive side: bits sampled on the clock rise
  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      start_seen_r <= 1'b0;
      st_r <= TLA_ST_IDLE;
      cnt_r <= '0;
      sh_r <= 8'h00;
      ack_pend_r <= 1'b0;
      evt_r <= '0;
      evt_tog_r <= 1'b0;
    end else if (start_seen_r != start_tog_r) begin
      start_seen_r <= start_tog_r;
      st_r <= TLA_ST_ADDR;
      cnt_r <= TLA_BIT_FIRST;
      sh_r <= {7'h00, sda_line};
      ack_pend_r <= 1'b0;
    end else if (cnt_r == TLA_ACK_BIT) begin
      cnt_r <= '0;
      ack_pend_r <= 1'b0;
      if (st_r == TLA_ST_READ && sda_line) begin
        st_r <= TLA_ST_IDLE;
      end
    end else begin
      cnt_r <= cnt_r + TLA_BIT_STEP;
      sh_r <= byte_in;
      if (cnt_r == TLA_LAST_BIT) begin
        unique case (st_r)
          TLA_ST_ADDR: begin
            ack_pend_r <= addr_hit;
            if (!addr_hit) begin
              st_r <= TLA_ST_IDLE;
            end else begin
              st_r <= byte_in[0] ? TLA_ST_READ : TLA_ST_PTR;
              evt_r <= '{kind: TLA_EV_ADDR, data: byte_in};
              evt_tog_r <= ~evt_tog_r;
            end
          end
          TLA_ST_PTR: begin
            ack_pend_r <= 1'b1;
            st_r <= TLA_ST_WDATA;
            evt_r <= '{kind: TLA_EV_PTR, data: byte_in};
            evt_tog_r <= ~evt_tog_r;
          end
          TLA_ST_WDATA: begin
            ack_pend_r <= 1'b1;
            evt_r <= '{kind: TLA_EV_DATA, data: byte_in};
            evt_tog_r <= ~evt_tog_r;
          end
          TLA_ST_READ, TLA_ST_IDLE: begin
            ack_pend_r <= 1'b0;
          end
          default: begin
            st_r <= TLA_ST_IDLE;
          end
        endcase
      end
    end
  end

  // transmit side: the line changes only while the clock is low;
  // rd_byte_r is held still by the system side until rd_tog_r moves
  always_ff @(negedge scl or negedge rstn) begin
    if (!rstn) begin
      tx_r <= 8'h00;
      drv_r <= 1'b0;
      rd_tog_r <= 1'b0;
    end else if (st_r == TLA_ST_READ && cnt_r == '0) begin
      tx_r <= rd_byte_r;
      drv_r <= ~rd_byte_r[7];
      rd_tog_r <= ~rd_tog_r;
    end else if (st_r == TLA_ST_READ && cnt_r != TLA_ACK_BIT) begin
      tx_r <= {tx_r[6:0], 1'b0};
      drv_r <= ~tx_r[6];
    end else begin
      drv_r <= ack_pend_r && (cnt_r == TLA_ACK_BIT);
    end
  end

  // open drain: only ever pulls low
  assign sda_drive = 1'b0;
  assign sda_oe_n = ~drv_r;

  // toggle crossings into the system clock; the event word is stable
  // for many serial bits after its toggle moves
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evt_sync_r <= '0;
      rd_sync_r <= '0;
    end else if (ce) begin
      evt_sync_r <= {evt_sync_r[1:0], evt_tog_r};
      rd_sync_r <= {rd_sync_r[1:0], rd_tog_r};
    end
  end

  assign evt_hit = ce && (evt_sync_r[2] ^ evt_sync_r[1]);
  assign rd_hit = ce && (rd_sync_r[2] ^ rd_sync_r[1]);
  assign wr_en = evt_hit && (evt_r.kind == TLA_EV_DATA) && !wr_lock_r;

  // pointer, read byte and temperature capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= TLA_A_TEMP_MSB;
      wr_lock_r <= 1'b0;
      rd_byte_r <= 8'h00;
      tsnap_r <= TLA_TEMP_RST;
      temp_r <= TLA_TEMP_RST;
    end else if (ce) begin
      if (new_res) begin
        temp_r <= temp_result;
      end
      if (evt_hit) begin
        unique case (evt_r.kind)
          TLA_EV_ADDR: begin
            tsnap_r <= temp_r;
            rd_byte_r <= rd_mux(ptr_r, temp_r);
          end
          TLA_EV_PTR: begin
            ptr_r <= evt_r.data;
            wr_lock_r <= 1'b0;
          end
          TLA_EV_DATA: begin
            // extra bytes after a pair or single byte are ignored
            if (!wr_lock_r && pair_msb(ptr_r)) begin
              ptr_r <= ptr_r + TLA_PTR_STEP;
            end else begin
              wr_lock_r <= 1'b1;
            end
          end
          default: begin
            wr_lock_r <= 1'b1;
          end
        endcase
      end else if (rd_hit && pair_msb(ptr_r)) begin
        ptr_r <= ptr_r + TLA_PTR_STEP;
        rd_byte_r <= rd_mux(ptr_r + TLA_PTR_STEP, tsnap_r);
      end
    end
  end

  // writable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= TLA_CFG_RST;
      upper_r <= TLA_UPPER_RST;
      lower_r <= TLA_LOWER_RST;
      crit_r <= TLA_CRIT_RST;
    end else if (ce && wr_en) begin
      case (ptr_r)
        TLA_A_CONFIG: cfg_r <= evt_r.data;
        TLA_A_UPPER_MSB: upper_r[15:8] <= evt_r.data;
        TLA_A_UPPER_LSB: upper_r[7:0] <= evt_r.data;
        TLA_A_LOWER_MSB: lower_r[15:8] <= evt_r.data;
        TLA_A_LOWER_LSB: lower_r[7:0] <= evt_r.data;
        TLA_A_CRIT_MSB: crit_r[15:8] <= evt_r.data;
        TLA_A_CRIT_LSB: crit_r[7:0] <= evt_r.data;
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  assign conv_mode = cfg_r[TLA_CFG_OPM_LO +: 2];
  assign shutdown = conv_mode == TLA_OPM_SHUTDOWN;
  assign shut_entry = wr_en && (ptr_r == TLA_A_CONFIG) && !shutdown &&
                      (evt_r.data[TLA_CFG_OPM_LO +: 2] == TLA_OPM_SHUTDOWN);
  assign cmp_mode = cfg_r[TLA_CFG_CMP_MODE];
  assign new_res = temp_valid && !shutdown;

  // signed two's complement compares; limits less hysteresis may wrap
  // if software sets limits near the ends of the range
  assign above_hi = $signed(temp_result) > $signed(upper_r);
  assign below_lo = $signed(temp_result) < $signed(lower_r);
  assign under_hi_rel = $signed(temp_result) < $signed(upper_r - hyst_amount);
  assign over_lo_rel = $signed(temp_result) > $signed(lower_r + hyst_amount);
  assign above_crit = $signed(temp_result) > $signed(crit_r);
  assign under_crit_rel = $signed(temp_result) < $signed(crit_r - hyst_amount);

  // limit alarm state; a new result beyond a limit wins over any clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alarm_r <= 1'b0;
      src_hi_r <= 1'b0;
    end else if (ce) begin
      if (new_res && (above_hi || below_lo)) begin
        alarm_r <= 1'b1;
        src_hi_r <= above_hi;
      end else if (cmp_mode) begin
        if (new_res && alarm_r && (src_hi_r ? under_hi_rel : over_lo_rel)) begin
          alarm_r <= 1'b0;
        end
      end else if (rd_hit || shut_entry) begin
        alarm_r <= 1'b0;
      end
    end
  end

  // critical alarm follows the result with the same hysteresis
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      crit_alm_r <= 1'b0;
    end else if (ce && new_res) begin
      if (above_crit) begin
        crit_alm_r <= 1'b1;
      end else if (under_crit_rel) begin
        crit_alm_r <= 1'b0;
      end
    end
  end

  assign limit_alarm_out = '{o: cfg_r[TLA_CFG_ALM_POL], oe_n: ~alarm_r};
  assign critical_alarm_out = '{o: cfg_r[TLA_CFG_CRIT_POL], oe_n: ~crit_alm_r};
endmodule

// *** sim/tla_alarm_chk.sv ***
// tla_alarm_chk: port-level assertions for the limit alarm block.
// assumes one clk domain view; scl is watched only as a level.
`timescale 1ns/1ps
module tla_alarm_chk
  import tla_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_drive,
  input wire logic sda_oe_n,
  input wire logic temp_valid,
  input wire logic [1:0] conv_mode,
  input wire tla_pkg::tla_pin_s limit_alarm_out,
  input wire tla_pkg::tla_pin_s critical_alarm_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic scl_q;
  logic [7:0] quiet_cnt;
  // serial side effects land a few clk after scl moves, so a short count suffices
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      quiet_cnt <= 8'h00;
    end else begin
      scl_q <= scl;
      if (scl != scl_q) begin
        quiet_cnt <= 8'h00;
      end else if (quiet_cnt != 8'hFF) begin
        quiet_cnt <= quiet_cnt + 8'h01;
      end
    end
  end
  property p_sda_low;
    !sda_oe_n |-> !sda_drive;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda driven high");
  property p_sda_edge;
    $fell(sda_oe_n) |-> !scl;
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("sda moved with scl high");
  property p_lim_set;
    $fell(limit_alarm_out.oe_n) |-> $past(temp_valid) && conv_mode != TLA_OPM_SHUTDOWN;
  endproperty
  a_lim_set: assert property (p_lim_set) else $error("alarm set without result");
  property p_lim_clr;
    $rose(limit_alarm_out.oe_n) |-> $past(temp_valid) || quiet_cnt < 8'h0C;
  endproperty
  a_lim_clr: assert property (p_lim_clr) else $error("alarm released without cause");
  property p_crit_set;
    $fell(critical_alarm_out.oe_n) |-> $past(temp_valid);
  endproperty
  a_crit_set: assert property (p_crit_set) else $error("critical set without result");
  property p_crit_clr;
    $rose(critical_alarm_out.oe_n) |-> $past(temp_valid);
  endproperty
  a_crit_clr: assert property (p_crit_clr) else $error("critical released early");
  property p_sd_hold;
    temp_valid && conv_mode == TLA_OPM_SHUTDOWN |=> !$fell(limit_alarm_out.oe_n);
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("result taken in shutdown");
  property p_pol;
    $changed(limit_alarm_out.o) |-> quiet_cnt < 8'h0C;
  endproperty
  a_pol: assert property (p_pol) else $error("polarity moved without write");
  c_set: cover property ($fell(limit_alarm_out.oe_n));
  c_clr: cover property ($rose(limit_alarm_out.oe_n));
  c_crit: cover property ($fell(critical_alarm_out.oe_n));
  c_sd: cover property (conv_mode == TLA_OPM_SHUTDOWN);
endmodule
bind tla_alarm tla_alarm_chk i_chk (
  .clk(clk), .rstn(rstn), .scl(scl), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n),
  .temp_valid(temp_valid), .conv_mode(conv_mode),
  .limit_alarm_out(limit_alarm_out), .critical_alarm_out(critical_alarm_out)
);

// *** sim/tla_host_model.sv ***
// tla_host_model: serial bus host that sets the pointer and moves bytes.
// assumes a pull-up on the data wire, resolved by the bench; scl idles high.
`timescale 1ns/1ps
module tla_host_model (
  output logic scl,
  output logic host_sda,
  input wire logic sda_line
);
  logic [6:0] dev_addr = 7'h49;
  initial begin
    scl = 1'b1;
    host_sda = 1'b1;
  end
  task automatic bit_w(input logic b);
    host_sda = b;
    #16 scl = 1'b1;
    #32 scl = 1'b0;
    #16;
  endtask
  task automatic bit_r(output logic b);
    host_sda = 1'b1;
    #16 scl = 1'b1;
    #16 b = sda_line;
    #16 scl = 1'b0;
    #16;
  endtask
  task automatic start();
    host_sda = 1'b1;
    #16 scl = 1'b1;
    #16 host_sda = 1'b0;
    #16 scl = 1'b0;
    #16;
  endtask
  task automatic stop();
    host_sda = 1'b0;
    #16 scl = 1'b1;
    #16 host_sda = 1'b1;
    #32;
  endtask
  task automatic byte_w(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_w(d[i]);
    end
    bit_r(ack);
  endtask
  task automatic byte_r(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_r(d[i]);
    end
    bit_w(last);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n, output logic nak);
    logic a;
    start();
    byte_w({dev_addr, 1'b0}, nak);
    byte_w(ptr, a);
    for (int i = n; i > 0; i--) begin
      byte_w(d[i*8-1 -: 8], a);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] d);
    logic a;
    d = 16'h0000;
    wr(ptr, 16'h0000, 0, a);
    start();
    byte_w({dev_addr, 1'b1}, a);
    for (int i = n; i > 0; i--) begin
      byte_r(i == 1, d[i*8-1 -: 8]);
    end
    stop();
  endtask
endmodule

// *** sim/tb.sv ***
// tb: self-checking bench for the limit alarm block.
// assumes the host model drives the serial side; results come from here.
`timescale 1ns/1ps
module tb;
  import tla_pkg::*;
  // identity value is arbitrary
  localparam logic [7:0] ID = 8'h3C;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic temp_valid = 1'b0;
  logic [15:0] temp_result = 16'h0000;
  logic scl, host_sda, sda_line, sda_drive, sda_oe_n;
  logic [1:0] conv_mode;
  tla_pin_s lim, crit;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  assign sda_line = host_sda & (sda_oe_n | sda_drive);
  tla_host_model i_host (.scl(scl), .host_sda(host_sda), .sda_line(sda_line));
  tla_alarm #(.ID_CODE(ID)) i_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .scl(scl), .sda_line(sda_line),
    .sda_drive(sda_drive), .sda_oe_n(sda_oe_n), .addr_sel(2'h1),
    .temp_result(temp_result), .temp_valid(temp_valid), .hyst_amount(16'h0200),
    .conv_mode(conv_mode), .limit_alarm_out(lim), .critical_alarm_out(crit)
  );
  task automatic finish_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(input logic [15:0] v);
    @(posedge clk);
    #1 temp_result = v;
    temp_valid = 1'b1;
    @(posedge clk);
    #1 temp_valid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic reg_rd(input logic [7:0] a, input int n, input logic [15:0] e);
    logic [15:0] d;
    i_host.rd(a, n, d);
    repeat (6) @(posedge clk);
    #1 chk(d, e);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d, input int n);
    logic nak;
    i_host.wr(a, d, n, nak);
    repeat (6) @(posedge clk);
    #1 chk(16'(nak), 16'h0000);
  endtask
  task automatic t_defaults();
    reg_rd(TLA_A_IDENT, 1, 16'(ID));
    reg_rd(TLA_A_CONFIG, 1, 16'(TLA_CFG_RST));
    reg_rd(TLA_A_UPPER_MSB, 2, TLA_UPPER_RST);
    reg_rd(TLA_A_LOWER_MSB, 2, TLA_LOWER_RST);
    reg_rd(TLA_A_CRIT_MSB, 2, TLA_CRIT_RST);
    chk(16'(conv_mode), 16'h0000);
  endtask
  task automatic t_regs();
    logic nak;
    i_host.dev_addr = 7'h4A;
    i_host.wr(TLA_A_CONFIG, 16'h0010, 1, nak);
    chk(16'(nak), 16'h0001);
    i_host.dev_addr = 7'h49;
    reg_rd(TLA_A_CONFIG, 1, 16'h0000);
    reg_wr(TLA_A_CONFIG, 16'h0010, 1);
    reg_rd(TLA_A_CONFIG, 1, 16'h0010);
    reg_wr(TLA_A_CONFIG, 16'h0000, 1);
    reg_wr(TLA_A_UPPER_MSB, 16'h2800, 2);
    reg_rd(TLA_A_UPPER_MSB, 2, 16'h2800);
    reg_wr(TLA_A_LOWER_LSB, 16'h0080, 1);
    reg_rd(TLA_A_LOWER_MSB, 2, 16'h0480);
    reg_wr(TLA_A_CRIT_MSB, 16'h3F80, 2);
    reg_rd(TLA_A_CRIT_MSB, 2, 16'h3F80);
    reg_wr(TLA_A_IDENT, 16'h0011, 1);
    reg_rd(TLA_A_IDENT, 1, 16'(ID));
  endtask
  task automatic t_intr();
    pulse(16'h1234);
    reg_rd(TLA_A_TEMP_MSB, 2, 16'h1234);
    chk(16'(lim.oe_n), 16'h0001);
    pulse(16'h2900);
    chk(16'(lim.oe_n), 16'h0000);
    chk(16'(lim.o), 16'h0000);
    reg_rd(TLA_A_CONFIG, 1, 16'h0000);
    chk(16'(lim.oe_n), 16'h0001);
    // a result offered while the clock enable is low is not stored
    ce = 1'b0;
    pulse(16'h2900);
    chk(16'(lim.oe_n), 16'h0001);
    ce = 1'b1;
    pulse(16'h2000);
    chk(16'(lim.oe_n), 16'h0001);
    pulse(16'h0400);
    chk(16'(lim.oe_n), 16'h0000);
    reg_wr(TLA_A_CONFIG, 16'h0060, 1);
    chk(16'(lim.oe_n), 16'h0001);
    chk(16'(conv_mode), 16'h0003);
    pulse(16'h2900);
    chk(16'(lim.oe_n), 16'h0001);
    reg_wr(TLA_A_CONFIG, 16'h0000, 1);
  endtask
  task automatic t_cmp();
    reg_wr(TLA_A_CONFIG, 16'h0018, 1);
    pulse(16'h2900);
    chk(16'(lim.oe_n), 16'h0000);
    chk(16'(lim.o), 16'h0001);
    reg_rd(TLA_A_IDENT, 1, 16'(ID));
    chk(16'(lim.oe_n), 16'h0000);
    pulse(16'h2700);
    chk(16'(lim.oe_n), 16'h0000);
    pulse(16'h2500);
    chk(16'(lim.oe_n), 16'h0001);
    pulse(16'h0400);
    pulse(16'h0600);
    chk(16'(lim.oe_n), 16'h0000);
    reg_wr(TLA_A_CONFIG, 16'h0078, 1);
    chk(16'(lim.oe_n), 16'h0000);
    reg_wr(TLA_A_CONFIG, 16'h001C, 1);
    pulse(16'h0700);
    chk(16'(lim.oe_n), 16'h0001);
    pulse(16'h4100);
    chk(16'(crit.oe_n), 16'h0000);
    chk(16'(crit.o), 16'h0001);
    pulse(16'h3D00);
    chk(16'(crit.oe_n), 16'h0001);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    t_defaults();
    t_regs();
    t_intr();
    t_cmp();
    finish_test();
  end
  initial begin
    #500_000;
    n_fail++;
    finish_test();
  end
endmodule
